// ### include/tag_consts.svh
// constants for the tag protocol dispatcher, option word and eeprom map
// assumes a single 25 MHz clock domain and word-wide eeprom access
`ifndef TAG_CONSTS_SVH
`define TAG_CONSTS_SVH

`define EE_WORDS      32
`define W_UID         5'h00
`define W_FAB         5'h01
`define W_CFG         5'h02
`define W_WLOCK       5'h03
`define W_RLOCK       5'h04
`define CFG_RESET     32'h2600_0000
`define CFG_FSCI      31:28
`define CFG_FWI       27:24
`define CFG_SDR       23
`define CFG_DS        22:20
`define CFG_DR        19:17
`define CFG_NL4       16
`define CFG_NFC       15
`define CFG_IRQ_ACT   13
`define CFG_MODE      12:11
`define MODE_L4       2'h0
`define MODE_L3       2'h1
`define MODE_FRAMING  2'h2
`define MODE_TRANSP   2'h3
`define SAK_BASE      8'h00
`define SAK_L4        8'h20
`define SAK_NFC       8'h40
`define RATS_BYTE     8'he0
`define PPS_NIB       4'hd
`define SBLK_NIB      4'hc
`define DESEL_LOW     3'h2
`define PROP_TOP      2'h1
`define CID_BIT       3

`endif

// ### include/tag_pkg.sv
// types shared by the tag protocol core and its eeprom
// state and class codes are set here; tag_consts.svh supplies the eeprom word numbers
`default_nettype none
package tag_pkg;
  typedef enum logic [6:0] {
    ST_INIT   = 7'h01,
    ST_INIT_W = 7'h02,
    ST_IDLE   = 7'h04,
    ST_FIRST  = 7'h08,
    ST_RATS   = 7'h10,
    ST_PROT   = 7'h20,
    ST_HALT   = 7'h40
  } state_t;

  typedef enum logic [2:0] {
    CL_FIFO  = 3'h0,
    CL_RATS  = 3'h1,
    CL_PPS   = 3'h2,
    CL_DESEL = 3'h3,
    CL_PROP  = 3'h4
  } frame_cls_t;

  typedef struct packed {
    logic [31:0][31:0] words;
    logic              ack;
    logic              refused;
    logic [31:0]       rdata;
  } mem_state_t;
endpackage : tag_pkg
`default_nettype wire

// ### core/tag_pin_sync.sv
// three-stage synchroniser for pins from outside the clock domain
// assumes levels; output moves only when stages two and three agree
`default_nettype none
module tag_pin_sync #(
  parameter int W = 4
) (
  input  wire logic         i_ref_clk,
  input  wire logic         i_sys_rst,
  input  wire logic [W-1:0] i_pins,
  output logic      [W-1:0] o_pins
);
  typedef struct packed {
    logic [W-1:0] s1;
    logic [W-1:0] s2;
    logic [W-1:0] s3;
    logic [W-1:0] q;
  } sync_t;

  sync_t r_q;
  sync_t r_d;

  always_comb begin
    r_d    = r_q;
    r_d.s1 = i_pins;
    r_d.s2 = r_q.s1;
    r_d.s3 = r_q.s2;
    for (int i = 0; i < W; i++) begin
      if (r_q.s2[i] == r_q.s3[i]) begin
        r_d.q[i] = r_q.s3[i];
      end
    end
  end

  always_ff @(posedge i_ref_clk or posedge i_sys_rst) begin
    if (i_sys_rst) begin
      r_q <= '0;
    end else begin
      r_q <= r_d;
    end
  end

  assign o_pins = r_q.q;
endmodule : tag_pin_sync
`default_nettype wire

// ### core/tag_eeprom.sv
// 32 x 32 nonvolatile word store with lock handling, registered read data
// assumes one request per cycle at most; answer comes the next cycle
`include "tag_consts.svh"
`default_nettype none
module tag_eeprom #(
  parameter logic [31:0] UID_LOW  = 32'h0000_0001, // arbitrary value
  parameter logic [31:0] FAB_DATA = 32'h0000_0000  // arbitrary value
) (
  input  wire logic        i_ref_clk,
  input  wire logic        i_sys_rst,
  input  wire logic        i_req,
  input  wire logic        i_we,
  input  wire logic [4:0]  i_addr,
  input  wire logic [31:0] i_wdata,
  output logic             o_ack,
  output logic             o_refused,
  output logic      [31:0] o_rdata
);
  tag_pkg::mem_state_t m_q;
  tag_pkg::mem_state_t m_d;

  always_comb begin
    m_d         = m_q;
    m_d.ack     = 1'b0;
    m_d.refused = 1'b0;
    if (i_req) begin
      m_d.ack   = 1'b1;
      m_d.rdata = m_q.words[i_addr];
      if (i_we) begin
        if (i_addr == `W_UID || i_addr == `W_FAB) begin
          m_d.refused = 1'b1;
        end else if (m_q.words[`W_WLOCK][i_addr]) begin
          m_d.refused = 1'b1;
        end else if (i_addr == `W_WLOCK || i_addr == `W_RLOCK) begin
          m_d.words[i_addr] = m_q.words[i_addr] | i_wdata;
        end else begin
          m_d.words[i_addr] = i_wdata;
        end
      end
    end
  end

  always_ff @(posedge i_ref_clk or posedge i_sys_rst) begin
    if (i_sys_rst) begin
      m_q              <= '0;
      // low id bytes in word 0
      m_q.words[`W_UID] <= UID_LOW;
      m_q.words[`W_FAB] <= FAB_DATA;
      m_q.words[`W_CFG] <= `CFG_RESET;
    end else begin
      m_q <= m_d;
    end
  end

  assign o_ack     = m_q.ack;
  assign o_refused = m_q.refused;
  assign o_rdata   = m_q.rdata;

  default clocking cb @(posedge i_ref_clk); endclocking
  default disable iff (i_sys_rst);

  property p_ro_refused;
    i_req && i_we && (i_addr == `W_UID || i_addr == `W_FAB)
      |=> o_refused && $stable(m_q.words[$past(i_addr)]);
  endproperty
  a_ro_refused: assert property (p_ro_refused) else $error("read-only word changed");

  property p_lock_refused;
    i_req && i_we && i_addr > `W_FAB && m_q.words[`W_WLOCK][i_addr]
      |=> o_ack && o_refused;
  endproperty
  a_lock_refused: assert property (p_lock_refused) else $error("locked write accepted");

  property p_otp_sticky;
    (($past(m_q.words[`W_WLOCK]) & ~m_q.words[`W_WLOCK]) == '0) &&
    (($past(m_q.words[`W_RLOCK]) & ~m_q.words[`W_RLOCK]) == '0);
  endproperty
  a_otp_sticky: assert property (p_otp_sticky) else $error("lock bit cleared");
endmodule : tag_eeprom
`default_nettype wire

// ### core/tag_protocol_core.sv
// level-4 dispatcher, option word decode, transparent bypass and eeprom port
// assumes rx bytes come from the framing logic on the same clock
`include "tag_consts.svh"
`default_nettype none
module tag_protocol_core (
  input  wire logic        i_ref_clk,
  input  wire logic        i_sys_rst,
  input  wire logic        i_field_on,
  input  wire logic        i_sak2_sent,
  input  wire logic        i_rx_valid,
  input  wire logic        i_rx_first,
  input  wire logic        i_rx_last,
  input  wire logic [7:0]  i_rx_data,
  input  wire logic        i_irq_clear,
  input  wire logic        i_tx_mod,
  input  wire logic        i_spi_miso,
  input  wire logic        i_ss_n,
  input  wire logic        i_mosi,
  input  wire logic        i_demod,
  input  wire logic        i_clk_extract,
  input  wire logic        i_ee_req,
  input  wire logic        i_ee_we,
  input  wire logic [4:0]  i_ee_addr,
  input  wire logic [31:0] i_ee_wdata,
  output logic             o_ready,
  output logic             o_fifo_wr,
  output logic      [7:0]  o_fifo_data,
  output logic             o_reply_ats,
  output logic             o_reply_pps,
  output logic             o_reply_deselect,
  output logic             o_run_proprietary,
  output logic      [3:0]  o_cid,
  output logic      [7:0]  o_sak2,
  output logic      [7:0]  o_ta1,
  output logic      [3:0]  o_fsci,
  output logic      [3:0]  o_fwi,
  output logic      [1:0]  o_mode,
  output logic             o_irq,
  output logic             o_modulate,
  output logic             o_miso,
  output logic             o_ee_ack,
  output logic             o_ee_refused,
  output logic      [31:0] o_ee_rdata
);
  typedef struct packed {
    tag_pkg::state_t     st;
    logic [31:0]         cfg;
    logic [3:0]          cid;
    tag_pkg::frame_cls_t cls;
    logic                fwd;
    logic                exec;
    logic                cid_ok;
    logic                need_cid;
    logic                irq;
    logic                fifo_wr;
    logic [7:0]          fifo_data;
    logic                rep_ats;
    logic                rep_pps;
    logic                rep_desel;
    logic                rep_prop;
    logic [7:0]          sak2;
    logic [7:0]          ta1;
    logic                modulate;
    logic                miso;
    logic                irq_pin;
    logic                ee_ack;
    logic                ee_refused;
    logic [31:0]         ee_rdata;
    logic                ready;
  } core_t;

  core_t c_q;
  core_t c_d;

  logic [3:0]  pins_s;
  logic        mem_req;
  logic        mem_we;
  logic [4:0]  mem_addr;
  logic        mem_ack;
  logic        mem_refused;
  logic [31:0] mem_rdata;
  logic        init_busy;

  tag_pin_sync #(.W(4)) u_sync (
    .i_ref_clk (i_ref_clk),
    .i_sys_rst (i_sys_rst),
    .i_pins    ({i_ss_n, i_mosi, i_demod, i_clk_extract}),
    .o_pins    (pins_s)
  );

  logic ss_hi_s;
  logic mosi_s;
  logic demod_s;
  logic clkx_s;
  assign ss_hi_s = pins_s[3];
  assign mosi_s  = pins_s[2];
  assign demod_s = pins_s[1];
  assign clkx_s  = pins_s[0];

  function automatic tag_pkg::frame_cls_t classify(input logic [7:0] b);
    if (b == `RATS_BYTE) begin
      classify = tag_pkg::CL_RATS;
    end else if (b[7:4] == `PPS_NIB) begin
      classify = tag_pkg::CL_PPS;
    end else if (b[7:4] == `SBLK_NIB && b[2:0] == `DESEL_LOW) begin
      classify = tag_pkg::CL_DESEL;
    end else if (b[7:6] == `PROP_TOP) begin
      classify = tag_pkg::CL_PROP;
    end else begin
      // old and new S(PARAMETERS) land here
      classify = tag_pkg::CL_FIFO;
    end
  endfunction : classify

  // init owns the eeprom until the option word is in
  assign init_busy = (c_q.st == tag_pkg::ST_INIT) || (c_q.st == tag_pkg::ST_INIT_W);
  // no mode or field gating on eeprom access
  assign mem_req  = (c_q.st == tag_pkg::ST_INIT) || (i_ee_req && !init_busy);
  assign mem_we   = i_ee_we && !init_busy;
  assign mem_addr = init_busy ? `W_CFG : i_ee_addr;

  tag_eeprom u_ee (
    .i_ref_clk (i_ref_clk),
    .i_sys_rst (i_sys_rst),
    .i_req     (mem_req),
    .i_we      (mem_we),
    .i_addr    (mem_addr),
    .i_wdata   (i_ee_wdata),
    .o_ack     (mem_ack),
    .o_refused (mem_refused),
    .o_rdata   (mem_rdata)
  );

  always_comb begin
    logic [1:0]          mode;
    logic                active;
    logic                accept;
    logic                cand;
    logic                ok;
    tag_pkg::frame_cls_t cls_v;
    c_d         = c_q;
    mode        = c_q.cfg[`CFG_MODE];
    active      = (c_q.st == tag_pkg::ST_FIRST) || (c_q.st == tag_pkg::ST_RATS) ||
                  (c_q.st == tag_pkg::ST_PROT);
    cand        = 1'b0;
    ok          = c_q.cid_ok;
    cls_v       = c_q.cls;
    c_d.fifo_wr = 1'b0;
    c_d.rep_ats   = 1'b0;
    c_d.rep_pps   = 1'b0;
    c_d.rep_desel = 1'b0;
    c_d.rep_prop  = 1'b0;
    c_d.ee_ack    = mem_ack && (c_q.st != tag_pkg::ST_INIT_W);
    c_d.ee_refused = mem_refused;
    c_d.ee_rdata  = mem_rdata;
    if (i_irq_clear) begin
      c_d.irq = 1'b0;
    end
    unique case (c_q.st)
      tag_pkg::ST_INIT: begin
        c_d.st = tag_pkg::ST_INIT_W;
      end
      // option word captured before any frame
      tag_pkg::ST_INIT_W: begin
        if (mem_ack) begin
          c_d.cfg = mem_rdata;
          c_d.st  = tag_pkg::ST_IDLE;
        end
      end
      tag_pkg::ST_IDLE, tag_pkg::ST_HALT: begin
        if (i_sak2_sent && mode != `MODE_FRAMING && mode != `MODE_TRANSP) begin
          c_d.st = tag_pkg::ST_FIRST;
          // active-entry interrupt, set wins over clear
          if (c_q.cfg[`CFG_IRQ_ACT]) begin
            c_d.irq = 1'b1;
          end
        end
      end
      tag_pkg::ST_FIRST, tag_pkg::ST_RATS, tag_pkg::ST_PROT: begin
        if (!i_field_on) begin
          c_d.st = tag_pkg::ST_IDLE;
        end
      end
    endcase
    accept = (mode == `MODE_FRAMING) ||
             ((mode == `MODE_L4 || mode == `MODE_L3) && active && i_field_on);
    if (i_rx_valid && accept && !init_busy) begin
      if (i_rx_first) begin
        cls_v = classify(i_rx_data);
        // RATS only first, PPS only right after
        if (mode == `MODE_L4 && active) begin
          unique case (cls_v)
            tag_pkg::CL_RATS:  cand = (c_q.st == tag_pkg::ST_FIRST);
            tag_pkg::CL_PPS:   cand = (c_q.st == tag_pkg::ST_RATS);
            tag_pkg::CL_DESEL: cand = 1'b1;
            tag_pkg::CL_PROP:  cand = 1'b1;
            tag_pkg::CL_FIFO:  cand = 1'b0;
          endcase
        end
        // out-of-turn RATS or PPS ends the window
        if (active && !cand) begin
          c_d.st = tag_pkg::ST_PROT;
        end
        c_d.cls      = cls_v;
        c_d.exec     = cand;
        c_d.fwd      = !cand;
        c_d.need_cid = (cls_v == tag_pkg::CL_RATS) ||
                       ((cls_v == tag_pkg::CL_DESEL || cls_v == tag_pkg::CL_PROP) &&
                        i_rx_data[`CID_BIT]);
        // PPS carries the CID in its first byte
        if (cls_v == tag_pkg::CL_PPS) begin
          ok = (i_rx_data[3:0] == c_q.cid);
        end else begin
          ok = 1'b1;
        end
        c_d.cid_ok = ok;
      end else if (c_q.need_cid) begin
        c_d.need_cid = 1'b0;
        if (c_q.cls == tag_pkg::CL_RATS) begin
          c_d.cid = i_rx_data[3:0];
        end else begin
          ok         = (i_rx_data[3:0] == c_q.cid);
          c_d.cid_ok = ok;
        end
      end
      if (i_rx_first ? !cand : c_q.fwd) begin
        c_d.fifo_wr   = 1'b1;
        c_d.fifo_data = i_rx_data;
      end
      if (i_rx_last && (i_rx_first ? cand : c_q.exec) && ok) begin
        unique case (cls_v)
          tag_pkg::CL_RATS: begin
            c_d.rep_ats = 1'b1;
            c_d.st      = tag_pkg::ST_RATS;
          end
          tag_pkg::CL_PPS: begin
            c_d.rep_pps = 1'b1;
            c_d.st      = tag_pkg::ST_PROT;
          end
          tag_pkg::CL_DESEL: begin
            c_d.rep_desel = 1'b1;
            c_d.st        = tag_pkg::ST_HALT;
          end
          tag_pkg::CL_PROP: begin
            c_d.rep_prop = 1'b1;
            c_d.st       = tag_pkg::ST_PROT;
          end
          tag_pkg::CL_FIFO: begin
            c_d.rep_prop = 1'b0;
          end
        endcase
      end
    end
    c_d.ready = (c_d.st != tag_pkg::ST_INIT) && (c_d.st != tag_pkg::ST_INIT_W);
    if (c_d.cfg[`CFG_NL4]) begin
      c_d.sak2 = `SAK_BASE;
    end else if (c_d.cfg[`CFG_NFC]) begin
      c_d.sak2 = `SAK_L4 | `SAK_NFC;
    end else begin
      c_d.sak2 = `SAK_L4;
    end
    c_d.ta1 = {c_d.cfg[`CFG_SDR], c_d.cfg[`CFG_DS], 1'b0, c_d.cfg[`CFG_DR]};
    if (mode == `MODE_TRANSP && ss_hi_s) begin
      c_d.modulate = mosi_s;
      c_d.miso     = clkx_s;
      c_d.irq_pin  = demod_s;
    end else begin
      c_d.modulate = i_tx_mod;
      c_d.miso     = i_spi_miso;
      c_d.irq_pin  = c_d.irq;
    end
  end

  always_ff @(posedge i_ref_clk or posedge i_sys_rst) begin
    if (i_sys_rst) begin
      c_q      <= '0;
      c_q.st   <= tag_pkg::ST_INIT;
      c_q.cls  <= tag_pkg::CL_FIFO;
      c_q.cfg  <= `CFG_RESET;
      c_q.sak2 <= `SAK_L4;
    end else begin
      c_q <= c_d;
    end
  end

  assign o_ready           = c_q.ready;
  assign o_fifo_wr         = c_q.fifo_wr;
  assign o_fifo_data       = c_q.fifo_data;
  assign o_reply_ats       = c_q.rep_ats;
  assign o_reply_pps       = c_q.rep_pps;
  assign o_reply_deselect  = c_q.rep_desel;
  assign o_run_proprietary = c_q.rep_prop;
  assign o_cid             = c_q.cid;
  assign o_sak2            = c_q.sak2;
  assign o_ta1             = c_q.ta1;
  // frame size and waiting time indices
  assign o_fsci            = c_q.cfg[`CFG_FSCI];
  assign o_fwi             = c_q.cfg[`CFG_FWI];
  assign o_mode            = c_q.cfg[`CFG_MODE];
  assign o_irq             = c_q.irq_pin;
  assign o_modulate        = c_q.modulate;
  assign o_miso            = c_q.miso;
  assign o_ee_ack          = c_q.ee_ack;
  assign o_ee_refused      = c_q.ee_refused;
  assign o_ee_rdata        = c_q.ee_rdata;

  default clocking cb @(posedge i_ref_clk); endclocking
  default disable iff (i_sys_rst);

  sequence s_rats_first;
    c_q.st == tag_pkg::ST_FIRST && c_q.cfg[`CFG_MODE] == `MODE_L4 && i_field_on &&
    i_rx_valid && i_rx_first && i_rx_last && i_rx_data == `RATS_BYTE;
  endsequence

  sequence s_late_rats;
    c_q.st == tag_pkg::ST_PROT && c_q.cfg[`CFG_MODE] == `MODE_L4 && i_field_on &&
    i_rx_valid && i_rx_first && i_rx_data == `RATS_BYTE;
  endsequence

  property p_rats_first;
    s_rats_first |=> o_reply_ats ##1 (c_q.st == tag_pkg::ST_RATS || !i_field_on);
  endproperty
  a_rats_first: assert property (p_rats_first) else $error("first RATS not answered");

  property p_late_rats;
    s_late_rats |=> o_fifo_wr && o_fifo_data == `RATS_BYTE && !o_reply_ats;
  endproperty
  a_late_rats: assert property (p_late_rats) else $error("late RATS executed");

  property p_fifo_class;
    i_rx_valid && i_rx_first && !init_busy && i_field_on && c_q.st == tag_pkg::ST_PROT &&
    c_q.cfg[`CFG_MODE] == `MODE_L4 && (i_rx_data[7:6] == 2'h0 || i_rx_data[7:6] == 2'h2 ||
    i_rx_data[7:4] == 4'hf) |=> o_fifo_wr && o_fifo_data == $past(i_rx_data);
  endproperty
  a_fifo_class: assert property (p_fifo_class) else $error("block not forwarded");

  property p_cid_mismatch;
    c_q.exec && c_q.need_cid && c_q.cls != tag_pkg::CL_RATS && i_rx_valid && !i_rx_first &&
    i_rx_last && i_field_on && i_rx_data[3:0] != c_q.cid
      |=> !o_reply_deselect && !o_run_proprietary;
  endproperty
  a_cid_mismatch: assert property (p_cid_mismatch) else $error("foreign CID acted on");

  property p_l3_forward;
    c_q.cfg[`CFG_MODE] == `MODE_L3 && c_q.st == tag_pkg::ST_PROT && i_field_on &&
    i_rx_valid |=> o_fifo_wr && !o_reply_ats && !o_run_proprietary;
  endproperty
  a_l3_forward: assert property (p_l3_forward) else $error("level-3 block not forwarded");

  property p_active_irq;
    c_q.st == tag_pkg::ST_IDLE && i_sak2_sent && c_q.cfg[`CFG_IRQ_ACT] &&
    c_q.cfg[`CFG_MODE] == `MODE_L4 |=> c_q.irq && o_irq;
  endproperty
  a_active_irq: assert property (p_active_irq) else $error("active entry irq missing");

  property p_bypass;
    c_q.cfg[`CFG_MODE] == `MODE_TRANSP && ss_hi_s
      |=> o_modulate == $past(mosi_s) && o_miso == $past(clkx_s) && o_irq == $past(demod_s);
  endproperty
  a_bypass: assert property (p_bypass) else $error("transparent bypass wrong");

  property p_serial_back;
    c_q.cfg[`CFG_MODE] == `MODE_TRANSP && !ss_hi_s |=> o_miso == $past(i_spi_miso);
  endproperty
  a_serial_back: assert property (p_serial_back) else $error("serial pins not restored");

  property p_init_quiet;
    init_busy |-> !c_q.fifo_wr && !c_q.rep_ats && c_q.st != tag_pkg::ST_FIRST;
  endproperty
  a_init_quiet: assert property (p_init_quiet) else $error("acted before config load");
endmodule : tag_protocol_core
`default_nettype wire

// ### verif/reader_model.sv
// reader side model: field, cascade-2 SAK event and frame bytes
// assumes the bench clock; each byte is a one-cycle valid pulse
`default_nettype none
module reader_model (
  input  wire logic       i_ref_clk,
  output logic            o_field_on,
  output logic            o_sak2_sent,
  output logic            o_rx_valid,
  output logic            o_rx_first,
  output logic            o_rx_last,
  output logic [7:0]      o_rx_data
);
  timeunit 1ns;
  timeprecision 1ps;
  initial begin
    o_field_on  = 1'b1;
    o_sak2_sent = 1'b0;
    o_rx_valid  = 1'b0;
    o_rx_first  = 1'b0;
    o_rx_last   = 1'b0;
    o_rx_data   = 8'h00;
  end
  task automatic activate;
    @(posedge i_ref_clk) o_sak2_sent <= 1'b1;
    @(posedge i_ref_clk) o_sak2_sent <= 1'b0;
    repeat (3) @(posedge i_ref_clk);
    #1;
  endtask : activate
  // idle data is inverted so a stale byte never looks valid
  task automatic put(input logic [7:0] b, input logic f, input logic l);
    @(posedge i_ref_clk) begin
      o_rx_valid <= 1'b1;
      o_rx_first <= f;
      o_rx_last  <= l;
      o_rx_data  <= b;
    end
    @(posedge i_ref_clk) begin
      o_rx_valid <= 1'b0;
      o_rx_first <= 1'b0;
      o_rx_last  <= 1'b0;
      o_rx_data  <= ~b;
    end
  endtask : put
  // CID rides in the frame; the tag decides
  task automatic frame(input logic [7:0] b0, input logic [7:0] b1, input int n);
    put(b0, 1'b1, n == 1);
    if (n == 2) put(b1, 1'b0, 1'b1);
    repeat (3) @(posedge i_ref_clk);
    #1;
  endtask : frame
endmodule : reader_model
`default_nettype wire

// ### verif/tb_tag_protocol_eeprom_config.sv
// bench for the tag core: eeprom port, option decode, block dispatch
// assumes the default option word, so mode is level-4, irq disabled
`default_nettype none
module tb_tag_protocol_eeprom_config;
  timeunit 1ns;
  timeprecision 1ps;
  logic        clk, rst, ee_req, ee_we, tx_mod, spi_miso, lo;
  logic [4:0]  ee_addr;
  logic [31:0] ee_wdata, ee_rdata;
  wire logic   fon, sak, rxv, rxf, rxl;
  wire logic [7:0] rxd;
  logic        ready, fwr, ats, pps, desel, irq, modl, miso, ack, refd, prop;
  logic [7:0]  fdat, sak2, ta1, flast;
  logic [3:0]  cid, fsci, fwi;
  logic [1:0]  mode;
  int          n_mismatch, checks_done, n_ats, n_pps, n_desel, n_fifo, n_prop;
  reader_model rdr_u (.i_ref_clk(clk), .o_field_on(fon), .o_sak2_sent(sak),
    .o_rx_valid(rxv), .o_rx_first(rxf), .o_rx_last(rxl), .o_rx_data(rxd));
  tag_protocol_core dut_u (.i_ref_clk(clk), .i_sys_rst(rst), .i_field_on(fon),
    .i_sak2_sent(sak), .i_rx_valid(rxv), .i_rx_first(rxf), .i_rx_last(rxl),
    .i_rx_data(rxd), .i_irq_clear(lo), .i_tx_mod(tx_mod), .i_spi_miso(spi_miso),
    .i_ss_n(lo), .i_mosi(lo), .i_demod(lo), .i_clk_extract(lo), .i_ee_req(ee_req),
    .i_ee_we(ee_we), .i_ee_addr(ee_addr), .i_ee_wdata(ee_wdata), .o_ready(ready),
    .o_fifo_wr(fwr), .o_fifo_data(fdat), .o_reply_ats(ats), .o_reply_pps(pps),
    .o_reply_deselect(desel), .o_run_proprietary(prop), .o_cid(cid), .o_sak2(sak2),
    .o_ta1(ta1), .o_fsci(fsci), .o_fwi(fwi), .o_mode(mode), .o_irq(irq),
    .o_modulate(modl), .o_miso(miso), .o_ee_ack(ack), .o_ee_refused(refd),
    .o_ee_rdata(ee_rdata));
  initial begin
    clk = 1'b0;
    forever #20 clk = ~clk;
  end
  always @(posedge clk) begin
    if (ats === 1'b1) n_ats++;
    if (pps === 1'b1) n_pps++;
    if (desel === 1'b1) n_desel++;
    if (prop === 1'b1) n_prop++;
    if (fwr === 1'b1) begin
      n_fifo++;
      flast = fdat;
    end
  end
  task automatic final_report;
    if (n_mismatch == 0 && checks_done > 0) begin
      $display("bench passed");
    end else begin
      $display("bench failed");
    end
    $finish;
  endtask : final_report
  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    checks_done++;
    if (got !== exp) begin
      n_mismatch++;
      $display("[FAIL] %0t got %h exp %h", $time, got, exp);
    end
  endtask : chk
  // one word access; answer is taken once ack is seen
  task automatic ee(input logic we, input logic [4:0] a, input logic [31:0] d);
    @(posedge clk) begin
      ee_req   <= 1'b1;
      ee_we    <= we;
      ee_addr  <= a;
      ee_wdata <= d;
    end
    @(posedge clk) ee_req <= 1'b0;
    #1;
    for (int i = 0; i < 8 && ack !== 1'b1; i++) @(posedge clk) #1;
    chk(ack, 1'b1);
  endtask : ee
  initial begin
    repeat (3000) @(posedge clk);
    n_mismatch++;
    final_report();
  end
  initial begin
    rst = 1'b1;
    lo = 1'b0;
    ee_req = 1'b0;
    ee_we = 1'b0;
    ee_addr = 5'h00;
    ee_wdata = 32'h0;
    tx_mod = 1'b0;
    spi_miso = 1'b0;
    repeat (12) @(posedge clk);
    rst <= 1'b0;
    for (int i = 0; i < 10 && ready !== 1'b1; i++) @(posedge clk) #1;
    chk(ready, 1'b1);
    chk({fsci, fwi}, 8'h26);
    chk(sak2, 8'h20);
    chk(ta1, 8'h00);
    chk(mode, 2'h0);
    ee(1'b0, 5'h02, 32'h0); chk(ee_rdata, 32'h2600_0000);
    ee(1'b0, 5'h00, 32'h0); chk(ee_rdata, 32'h0000_0001);
    ee(1'b1, 5'h00, 32'hffff_ffff); chk(refd, 1'b1);
    ee(1'b0, 5'h00, 32'h0); chk(ee_rdata, 32'h0000_0001);
    ee(1'b1, 5'h05, 32'ha5a5_5a5a); chk(refd, 1'b0);
    ee(1'b0, 5'h05, 32'h0); chk(ee_rdata, 32'ha5a5_5a5a);
    ee(1'b1, 5'h03, 32'h0000_0020); chk(refd, 1'b0);
    ee(1'b1, 5'h03, 32'h0); ee(1'b0, 5'h03, 32'h0); chk(ee_rdata, 32'h20);
    ee(1'b1, 5'h05, 32'h0); chk(refd, 1'b1);
    ee(1'b0, 5'h05, 32'h0); chk(ee_rdata, 32'ha5a5_5a5a);
    @(posedge clk) begin
      tx_mod   <= 1'b1;
      spi_miso <= 1'b1;
    end
    repeat (3) @(posedge clk);
    #1;
    chk({modl, miso}, 2'h3);
    rdr_u.activate();
    chk(irq, 1'b0);
    rdr_u.frame(8'he0, 8'h21, 2); chk(n_ats, 1);
    chk(cid, 4'h1);
    rdr_u.frame(8'hd1, 8'h11, 2); chk(n_pps, 1);
    rdr_u.frame(8'h02, 8'h00, 2); chk(n_fifo, 2);
    rdr_u.frame(8'he0, 8'h21, 2);
    rdr_u.frame(8'hd1, 8'h11, 2); chk(n_fifo, 6);
    chk(n_ats + n_pps, 2);
    rdr_u.frame(8'hc0, 8'h00, 1);
    rdr_u.frame(8'hf0, 8'h00, 1); chk(n_fifo, 8);
    rdr_u.frame(8'ha2, 8'h00, 1); chk(flast, 8'ha2);
    rdr_u.frame(8'h42, 8'h00, 1); chk(n_prop, 1);
    ee(1'b0, 5'h02, 32'h0); chk(ee_rdata, 32'h2600_0000);
    rdr_u.frame(8'hca, 8'h02, 2); chk(n_desel, 0);
    rdr_u.frame(8'hca, 8'h01, 2); chk(n_desel, 1);
    chk(n_fifo, 9);
    final_report();
  end
endmodule : tb_tag_protocol_eeprom_config
`default_nettype wire
